/* inc/dbg_pkg.sv */
// Package with register map, reset values and field layout of the dual-byte GPIO ports.
package dbg_pkg;
   // Printed offsets are not multiples of four, so they are register indexes.
   localparam logic [7:0] IDX_FIRST_DIR = 8'h10;
   localparam logic [7:0] IDX_FIRST_DATA = 8'h11;
   localparam logic [7:0] IDX_SECOND_DIR = 8'h12;
   localparam logic [7:0] IDX_SECOND_DATA = 8'h13;
   localparam logic [7:0] IDX_ANALOG_CTRL = 8'h15;
   localparam logic [7:0] IDX_RMW_CTRL = 8'h16;
   localparam int ADDR_W = 12;
   // Reset values.
   localparam logic [7:0] DIR_RESET = 8'hFF;
   localparam logic [7:0] ANALOG_CTRL_RESET = 8'h00;
   localparam logic [7:0] DATA_POR_RESET = 8'h00;
   localparam logic [3:0] UPPER_LATCH_RESET = 4'h0;
   // Analog control layout: bit 4 unimplemented, bits 3:0 port configuration.
   localparam logic [7:0] ANALOG_CTRL_MASK = 8'hEF;
   localparam int PCFG_LSB = 0;
   localparam int PCFG_W = 4;
   // Configuration value that makes the shared upper pins digital.
   localparam logic [3:0] PCFG_ALL_DIGITAL = 4'hE;
   localparam int FIRST_ANALOG_CHANNEL = 12;
   // Read-modify-write control layout: bits 2:0 bit number, bits 5:4 operation, bit 6 port select.
   localparam int RMW_BIT_LSB = 0;
   localparam int RMW_OP_LSB = 4;
   localparam int RMW_PORT_BIT = 6;
   typedef enum logic [1:0] {
      DBG_OP_CLEAR = 2'b00,
      DBG_OP_SET = 2'b01,
      DBG_OP_TOGGLE = 2'b11
   } dbg_op_t;
   // One port's pin signals.
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } dbg_pins_t;
endpackage : dbg_pkg

/* hdl/dbg_ports.sv */
// Two 8-bit bidirectional GPIO ports with APB register access and analog sharing on the first port.
// What this block does
// - Direction bit one makes pin input; zero drives it from the latch. First port upper pins held analog stay undriven whatever their direction bit.
// - Reading first port data returns pin levels, not latch contents.
// - Writing first port data loads the latch regardless of direction.
// - Second port data reads pins and writes latch likewise.
// - First port upper four pins are shared with four analog channels.
// - First port pins 4 to 7 map to analog channels 12 to 15.
// - After reset the upper pins are analog until software reconfigures them.
// - First port lower four pins are digital I/O only.
// - All second port pins are plain digital I/O.
// - First port direction resets to all ones on every reset.
// - Second port direction resets to all ones on every reset.
// - Digital latches clear to zero on power-on, kept otherwise; first upper latch resets zero.
// - Port-writing instructions read the register, modify, then write back.
// - Read-modify-write takes pin levels, applies operation, writes all eight bits.
// - Input pins get their sampled level written into the latch by read-modify-write.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dbg_ports
   import dbg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] first_port_in,
   output logic [7:0] first_port_out,
   output logic [7:0] first_port_oe,
   input wire logic [7:0] second_port_in,
   output logic [7:0] second_port_out,
   output logic [7:0] second_port_oe,
   output logic [3:0] analog_select
);
   // Software-visible register state.
   logic [7:0] first_port_direction;
   logic [7:0] second_port_direction;
   logic [7:0] analog_control_one;

   // Output latches, split by reset behaviour so each half has one owner.
   logic [3:0] first_upper_latch;
   logic [3:0] first_lower_latch;
   logic [7:0] second_port_latch;
   logic [7:0] first_port_latch;

   // Bus phase decode.
   logic setup;
   logic access;
   logic wr;
   logic [7:0] wbyte;

   // One write strobe per register, all qualified by the access phase.
   logic wr_first_dir;
   logic wr_first_data;
   logic wr_second_dir;
   logic wr_second_data;
   logic wr_analog_ctrl;
   logic wr_rmw_ctrl;

   // Read path.
   logic [7:0] next_rdata;
   logic hit;

   // Pin view as seen by software.
   logic [7:0] first_pins;
   logic [3:0] upper_digital;
   logic [7:0] first_digital_mask;
   logic [7:0] next_first_oe;

   // Read-modify-write fields and result.
   logic [2:0] rmw_bit;
   logic [1:0] rmw_op;
   logic rmw_on_second;
   logic [7:0] rmw_source;
   logic [7:0] rmw_value;
   logic rmw_first;
   logic rmw_second;

   // Byte address of a register from its index.
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {{(ADDR_W-10){1'b0}}, idx, 2'b00};
   endfunction : reg_addr

   // Applies a bit operation to a byte read from the pins.
   function automatic logic [7:0] bit_op(input logic [7:0] src, input logic [2:0] bnum, input logic [1:0] op);
      logic [7:0] m;
      m = 8'h01 << bnum;
      case (op)
         DBG_OP_CLEAR: bit_op = src & ~m;
         DBG_OP_SET: bit_op = src | m;
         DBG_OP_TOGGLE: bit_op = src ^ m;
         default: bit_op = src;
      endcase
   endfunction : bit_op

   // Shared upper pins are digital only when the configuration field says so.
   // Every other field value keeps them analog, which is also the reset state.
   assign upper_digital = (analog_control_one[PCFG_LSB +: PCFG_W] == PCFG_ALL_DIGITAL) ? 4'hF : 4'h0;

   // Lower pins never have an alternate function, so their mask bits are fixed.
   assign first_digital_mask = {upper_digital, 4'hF};

   // Analog-assigned pins read as zero on the digital path; lower pins are always digital.
   assign first_pins = {first_port_in[7:4] & upper_digital, first_port_in[3:0]};

   // The whole first latch, reassembled for the pin driver.
   assign first_port_latch = {first_upper_latch, first_lower_latch};

   // Bus phases: setup is the first cycle of a transfer, access the second.
   assign setup = psel && !penable;
   assign access = psel && penable;

   // Only the low byte lane carries register data; a write without it is ignored.
   assign wr = access && pwrite && pstrb[0];
   assign wbyte = pwdata[7:0];

   // Per-register write strobes.
   assign wr_first_dir = wr && (paddr == reg_addr(IDX_FIRST_DIR));
   assign wr_first_data = wr && (paddr == reg_addr(IDX_FIRST_DATA));
   assign wr_second_dir = wr && (paddr == reg_addr(IDX_SECOND_DIR));
   assign wr_second_data = wr && (paddr == reg_addr(IDX_SECOND_DATA));
   assign wr_analog_ctrl = wr && (paddr == reg_addr(IDX_ANALOG_CTRL));
   assign wr_rmw_ctrl = wr && (paddr == reg_addr(IDX_RMW_CTRL));

   // Read-modify-write command fields.
   assign rmw_bit = pwdata[RMW_BIT_LSB +: 3];
   assign rmw_op = pwdata[RMW_OP_LSB +: 2];
   assign rmw_on_second = pwdata[RMW_PORT_BIT];

   // The source is the pins, never the latch, so input pins overwrite their latch bits.
   assign rmw_source = rmw_on_second ? second_port_in : first_pins;
   assign rmw_value = bit_op(rmw_source, rmw_bit, rmw_op);

   // A command writes all eight result bits to the chosen port's latch.
   assign rmw_first = wr_rmw_ctrl && !rmw_on_second;
   assign rmw_second = wr_rmw_ctrl && rmw_on_second;

   // Address decode for reads and the unmapped check.
   always_comb begin
      hit = 1'b1;
      next_rdata = 8'h00;
      if (paddr == reg_addr(IDX_FIRST_DIR)) begin
         next_rdata = first_port_direction;
      end else if (paddr == reg_addr(IDX_FIRST_DATA)) begin
         next_rdata = first_pins;
      end else if (paddr == reg_addr(IDX_SECOND_DIR)) begin
         next_rdata = second_port_direction;
      end else if (paddr == reg_addr(IDX_SECOND_DATA)) begin
         next_rdata = second_port_in;
      end else if (paddr == reg_addr(IDX_ANALOG_CTRL)) begin
         next_rdata = analog_control_one;
      end else if (paddr == reg_addr(IDX_RMW_CTRL)) begin
         next_rdata = 8'h00;
      end else begin
         hit = 1'b0;
      end
   end

   // One enable per first-port pin: it drives only when cleared to zero and not held analog.
   for (genvar g = 0; g < 8; g++) begin : g_first_oe
      assign next_first_oe[g] = !first_port_direction[g] && first_digital_mask[g];
   end

   // First port direction comes up as all inputs on every reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_port_direction <= DIR_RESET;
      end else if (wr_first_dir) begin
         first_port_direction <= wbyte;
      end
   end

   // Second port direction comes up as all inputs on every reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         second_port_direction <= DIR_RESET;
      end else if (wr_second_dir) begin
         second_port_direction <= wbyte;
      end
   end

   // Analog control resets so the shared pins start as analog inputs.
   // The unimplemented bit is masked on write and therefore always reads zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_control_one <= ANALOG_CTRL_RESET;
      end else if (wr_analog_ctrl) begin
         analog_control_one <= wbyte & ANALOG_CTRL_MASK;
      end
   end

   // Upper first-port latch clears on any reset, warm or cold.
   // A read-modify-write wins over a plain write; both cannot hit in one cycle anyway.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_upper_latch <= UPPER_LATCH_RESET;
      end else if (rmw_first) begin
         first_upper_latch <= rmw_value[7:4];
      end else if (wr_first_data) begin
         first_upper_latch <= wbyte[7:4];
      end
   end

   // Lower first-port latch is only cleared by a cold reset and holds across warm reset.
   // Writes are blocked while the warm reset is asserted so the latch keeps its value.
   always_ff @(posedge pclk) begin
      if (!por_n) begin
         first_lower_latch <= DATA_POR_RESET[3:0];
      end else if (presetn) begin
         if (rmw_first) begin
            first_lower_latch <= rmw_value[3:0];
         end else if (wr_first_data) begin
            first_lower_latch <= wbyte[3:0];
         end
      end
   end

   // Second-port latch behaves like the lower first-port latch across resets.
   always_ff @(posedge pclk) begin
      if (!por_n) begin
         second_port_latch <= DATA_POR_RESET;
      end else if (presetn) begin
         if (rmw_second) begin
            second_port_latch <= rmw_value;
         end else if (wr_second_data) begin
            second_port_latch <= wbyte;
         end
      end
   end

   // First port drivers: the latch is shown and only output pins are enabled.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_port_out <= 8'h00;
         first_port_oe <= 8'h00;
      end else begin
         first_port_out <= first_port_latch;
         first_port_oe <= next_first_oe;
      end
   end

   // Second port drivers: every pin is plain digital, so direction alone decides.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         second_port_out <= 8'h00;
         second_port_oe <= 8'h00;
      end else begin
         second_port_out <= second_port_latch;
         second_port_oe <= ~second_port_direction;
      end
   end

   // Analog channel select: bit i marks first-port pin 4+i as analog channel 12+i.
   // It reads zero during reset and shows all four channels at the first edge after.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_select <= 4'h0;
      end else begin
         analog_select <= ~upper_digital;
      end
   end

   // Ready answers in the first access cycle, so the bus never sees a wait state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // Error flag rides with ready when the address maps to no register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup && !hit;
      end
   end

   // Read data is captured at setup and stands for the single access cycle.
   // Pins are sampled one cycle before the answer, which the user must allow for.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= {24'h00_0000, next_rdata};
      end else begin
         prdata <= 32'h0000_0000;
      end
   end

   // Spare decode kept readable: the command register itself is write only.
   // Reads of it return zero through the address decode above.
endmodule : dbg_ports
`default_nettype wire

/* sim/dbg_monitor.sv */
// Checker that watches the port-level behaviour of the GPIO ports.
`timescale 1ns/1ps
`default_nettype none
module dbg_monitor
   import dbg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [7:0] second_port_in,
   input wire logic [7:0] second_port_out,
   input wire logic [7:0] second_port_oe,
   input wire logic [7:0] first_port_oe,
   input wire logic [3:0] analog_select
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // A completed write whose low byte is enabled.
   sequence s_wr(a);
      psel && penable && pready && pwrite && pstrb[0] && paddr == a;
   endsequence
   property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
   a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
   property p_err; pready |-> pslverr == !(paddr inside {12'h040, 12'h044, 12'h048, 12'h04C, 12'h054, 12'h058});
   endproperty
   a_err: assert property (p_err) else $error("error flag does not match the map");
   property p_pins; pready && !pwrite && paddr == 12'h04C |-> prdata == {24'h0, $past(second_port_in)}; endproperty
   a_pins: assert property (p_pins) else $error("second port read is not the pins");
   property p_dir; s_wr(12'h048) |-> ##2 second_port_oe == ~$past(pwdata[7:0], 2); endproperty
   a_dir: assert property (p_dir) else $error("enables do not follow direction");
   property p_lat; s_wr(12'h04C) |-> ##2 second_port_out == $past(pwdata[7:0], 2); endproperty
   a_lat: assert property (p_lat) else $error("second latch not loaded");
   property p_ana; (first_port_oe[7:4] & analog_select) == 4'h0; endproperty
   a_ana: assert property (p_ana) else $error("analog pin is driven");
   property p_rst; $rose(presetn) |=> analog_select == 4'hF; endproperty
   a_rst: assert property (p_rst) else $error("upper pins not analog after reset");
   property p_dig; s_wr(12'h054) ##0 pwdata[3:0] == 4'hE |-> ##2 analog_select == 4'h0; endproperty
   a_dig: assert property (p_dig) else $error("upper pins not made digital");
endmodule : dbg_monitor
`default_nettype wire

/* sim/dbg_board.sv */
// Board model that drives each port pin wherever the device leaves it as input.
`timescale 1ns/1ps
`default_nettype none
module dbg_board
   import dbg_pkg::*;
(
   input wire dbg_pins_t drv,
   input wire logic [7:0] ext,
   output logic [7:0] pin
);
   // A driven pin shows the latch; any other pin shows the outside circuit.
   assign pin = (drv.oe & drv.out) | (~drv.oe & ext);
endmodule : dbg_board
`default_nettype wire

/* sim/dbg_ports_tb_top.sv */
// Testbench for the GPIO ports with a board model on both ports.
`timescale 1ns/1ps
`default_nettype none
module dbg_ports_tb_top;
   logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, d;
   logic [3:0] pstrb = 4'hF, asel;
   logic [7:0] p1, p2, o1, o2, e1, e2;
   logic [7:0] rmw [3] = '{8'h57, 8'h30, 8'h45};
   logic [7:0] rx [3] = '{8'hB1, 8'hA7, 8'h11};
   int errors = 0, compares = 0, cyc = 0;
   dbg_ports dbg_ports_i (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .first_port_in(p1), .first_port_out(o1), .first_port_oe(e1), .second_port_in(p2),
      .second_port_out(o2), .second_port_oe(e2), .analog_select(asel));
   dbg_board dbg_board_i [1:0] (.drv({o2, e2, o1, e1}), .ext({8'h3C, 8'h96}), .pin({p2, p1}));
   initial forever #2.5 pclk = ~pclk;
   // Cuts a hung run short.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         finish_test();
      end
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, v};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      compares++;
      if (g !== x) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task automatic rdc(input logic [11:0] a, input logic [7:0] x);
      xfer(1'b0, a, 8'h00);
      chk(d[7:0], x);
   endtask : rdc
   task automatic wt();
      repeat (2) @(posedge pclk);
   endtask : wt
   task automatic finish_test();
      if (errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   // Cold reset, then register defaults, analog sharing, pin paths, read-modify-write and a warm reset.
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      por_n <= 1'b1;
      wt();
      chk(o1, 8'h00);
      chk(o2, 8'h00);
      rdc(12'h040, 8'hFF);
      rdc(12'h048, 8'hFF);
      rdc(12'h054, 8'h00);
      rdc(12'h044, 8'h06);
      chk({4'h0, asel}, 8'h0F);
      xfer(1'b0, 12'h050, 8'h00);
      chk({7'h0, e}, 8'h01);
      xfer(1'b1, 12'h054, 8'hFF);
      rdc(12'h054, 8'hEF);
      xfer(1'b1, 12'h054, 8'h0E);
      wt();
      chk({4'h0, asel}, 8'h00);
      xfer(1'b1, 12'h044, 8'hA5);
      wt();
      chk(o1, 8'hA5);
      xfer(1'b1, 12'h040, 8'h0F);
      wt();
      chk(e1, 8'hF0);
      rdc(12'h044, 8'hA6);
      xfer(1'b1, 12'h04C, 8'h81);
      xfer(1'b1, 12'h048, 8'hF0);
      wt();
      chk(e2, 8'h0F);
      rdc(12'h04C, 8'h31);
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, 12'h058, rmw[i]);
         wt();
         chk(rmw[i][6] ? o2 : o1, rx[i]);
      end
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      wt();
      chk(o2, 8'h11);
      chk(o1, 8'h07);
      rdc(12'h040, 8'hFF);
      finish_test();
   end
endmodule : dbg_ports_tb_top
bind dbg_ports dbg_monitor dbg_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .pready, .pslverr, .second_port_in, .second_port_out, .second_port_oe, .first_port_oe, .analog_select);
`default_nettype wire
